//--- rtl/pdc_div_cnt.sv
// programmable tick divider: one pulse every lim_i+1 input ticks
`timescale 1ns/1ps
`default_nettype none
module pdc_div_cnt #(
	parameter int W = 20
) (
	input  wire logic         clock_i,  // register clock
	input  wire logic         rst_i,    // async reset, high
	input  wire logic         ce_i,     // clock enable
	input  wire logic         tick_i,   // input tick
	input  wire logic [W-1:0] lim_i,    // division ratio minus one
	output logic              pulse_o   // one pulse per ratio ticks
);
	logic [W-1:0] count_q;

	if (W < 1)
	begin : g_bad_width
		$error("pdc_div_cnt: width must be at least one");
	end

	// count ticks; a shrunk limit below count wraps at once
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			count_q <= '0;
		else if (ce_i && tick_i)
		begin
			if (count_q >= lim_i)
				count_q <= '0;
			else
				count_q <= count_q + W'(1);
		end
	end

	// pulse on the tick that closes a period
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			pulse_o <= 1'b0;
		else if (ce_i)
			pulse_o <= tick_i && (count_q >= lim_i);
	end
endmodule
`default_nettype wire

//--- rtl/pdc_pkg.sv
// shared constants for the pll divider configuration block
package pdc_pkg;
	// register offsets
	localparam logic [7:0] OUT1_LSDIV_MID_ADDR      = 8'h20;
	localparam logic [7:0] OUT1_LSDIV_LOW_ADDR      = 8'h21;
	localparam logic [7:0] OUT2_LSDIV_HIGH_ADDR     = 8'h22;
	localparam logic [7:0] OUT2_LSDIV_MID_ADDR      = 8'h23;
	localparam logic [7:0] OUT2_LSDIV_LOW_ADDR      = 8'h24;
	localparam logic [7:0] FB_HSDIV_LSDIV_HIGH_ADDR = 8'h28;
	// reset values
	localparam logic [7:0] OUT1_LSDIV_MID_RST       = 8'h00;
	localparam logic [7:0] OUT1_LSDIV_LOW_RST       = 8'h31;
	localparam logic [7:0] OUT2_LSDIV_HIGH_RST      = 8'h00;
	localparam logic [7:0] OUT2_LSDIV_MID_RST       = 8'h00;
	localparam logic [7:0] OUT2_LSDIV_LOW_RST       = 8'h31;
	localparam logic [7:0] FB_HSDIV_LSDIV_HIGH_RST  = 8'hC0;
	// field layout
	localparam int         NIBBLE_HI                = 3;
	localparam int         NIBBLE_LO                = 0;
	localparam int         HS_CODE_HI               = 7;
	localparam int         HS_CODE_LO               = 5;
	localparam logic [7:0] OUT2_HIGH_WMASK          = 8'h0F;
	localparam logic [7:0] FB_HIGH_WMASK            = 8'hEF;
	localparam logic [7:0] UNMAPPED_READ            = 8'h00;
	// high-speed code 000 divides by 4, so limit is code plus 3
	localparam logic [3:0] HS_LIMIT_BASE            = 4'h3;
	localparam int         LS_WIDTH                 = 20;
	localparam int         HS_WIDTH                 = 4;
endpackage

//--- rtl/pdc_top.sv
// divider configuration registers and the divider chains they steer
//
// Summary of operation
// - output low-speed divider ratio is field plus one
// - feedback high-speed code 000 divides by four
// - feedback high-speed feeds low-speed, then phase detector
// - output low bytes reset 0x31, mid zero
// - feedback high register resets to 0xC0
// - shared output high-speed divider feeds both outputs
`timescale 1ns/1ps
`default_nettype none
module pdc_top #(
	parameter int LSW = pdc_pkg::LS_WIDTH
) (
	input  wire logic           clock_i,               // register clock, 10 MHz
	input  wire logic           rst_i,                 // async reset, high
	input  wire logic           ce_i,                  // clock enable, freezes all
	input  wire logic [7:0]     reg_addr_i,            // register address
	input  wire logic [7:0]     reg_wdata_i,           // write data
	input  wire logic           reg_wr_i,              // write strobe
	input  wire logic           reg_rd_i,              // read strobe
	output logic      [7:0]     reg_rdata_o,           // read data, next cycle
	input  wire logic [3:0]     out1_lowspeed_high_i,  // output one upper nibble
	input  wire logic [15:0]    fb_lowspeed_low16_i,   // feedback lower sixteen bits
	input  wire logic [2:0]     out_highspeed_code_i,  // shared output hs code
	input  wire logic           vco_tick_i,            // one tick per vco cycle
	output logic [LSW-1:0]      out1_lowspeed_div_o,   // output one field
	output logic [LSW-1:0]      out2_lowspeed_div_o,   // output two field
	output logic [LSW-1:0]      fb_lowspeed_div_o,     // feedback low-speed field
	output logic [2:0]          fb_highspeed_div_o,    // feedback hs code
	output logic                clock_output_one_o,    // output one pulse
	output logic                clock_output_two_o,    // output two pulse
	output logic                phase_det_fb_o         // feedback pulse to detector
);
	logic [7:0] out1_mid_q;
	logic [7:0] out1_low_q;
	logic [7:0] out2_high_q;
	logic [7:0] out2_mid_q;
	logic [7:0] out2_low_q;
	logic [7:0] fb_high_q;
	logic [7:0] rdata_d;
	logic       out_hs_tick;
	logic       fb_hs_tick;
	logic       out1_pulse;
	logic       out2_pulse;
	logic       fb_pulse;
	logic [pdc_pkg::HS_WIDTH-1:0] out_hs_lim;
	logic [pdc_pkg::HS_WIDTH-1:0] fb_hs_lim;
	logic [LSW-1:0] out1_val;
	logic [LSW-1:0] out2_val;
	logic [LSW-1:0] fb_val;

	if (LSW != pdc_pkg::LS_WIDTH)
	begin : g_bad_width
		$error("pdc_top: low-speed width is fixed by the register layout");
	end

	// output register resets
	// writable byte registers; reserved bits never take a one
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			out1_mid_q  <= pdc_pkg::OUT1_LSDIV_MID_RST;
			out1_low_q  <= pdc_pkg::OUT1_LSDIV_LOW_RST;
			out2_high_q <= pdc_pkg::OUT2_LSDIV_HIGH_RST;
			out2_mid_q  <= pdc_pkg::OUT2_LSDIV_MID_RST;
			out2_low_q  <= pdc_pkg::OUT2_LSDIV_LOW_RST;
		end
		else if (ce_i && reg_wr_i)
		begin
			case (reg_addr_i)
				pdc_pkg::OUT1_LSDIV_MID_ADDR:  out1_mid_q  <= reg_wdata_i;
				pdc_pkg::OUT1_LSDIV_LOW_ADDR:  out1_low_q  <= reg_wdata_i;
				pdc_pkg::OUT2_LSDIV_HIGH_ADDR: out2_high_q <= reg_wdata_i & pdc_pkg::OUT2_HIGH_WMASK;
				pdc_pkg::OUT2_LSDIV_MID_ADDR:  out2_mid_q  <= reg_wdata_i;
				pdc_pkg::OUT2_LSDIV_LOW_ADDR:  out2_low_q  <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// feedback register reset
	// bit 4 is reserved and stays zero
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			fb_high_q <= pdc_pkg::FB_HSDIV_LSDIV_HIGH_RST;
		else if (ce_i && reg_wr_i && reg_addr_i == pdc_pkg::FB_HSDIV_LSDIV_HIGH_ADDR)
			fb_high_q <= reg_wdata_i & pdc_pkg::FB_HIGH_WMASK;
	end

	// read mux; unmapped addresses read as zero
	always_comb
	begin
		case (reg_addr_i)
			pdc_pkg::OUT1_LSDIV_MID_ADDR:      rdata_d = out1_mid_q;
			pdc_pkg::OUT1_LSDIV_LOW_ADDR:      rdata_d = out1_low_q;
			pdc_pkg::OUT2_LSDIV_HIGH_ADDR:     rdata_d = out2_high_q;
			pdc_pkg::OUT2_LSDIV_MID_ADDR:      rdata_d = out2_mid_q;
			pdc_pkg::OUT2_LSDIV_LOW_ADDR:      rdata_d = out2_low_q;
			pdc_pkg::FB_HSDIV_LSDIV_HIGH_ADDR: rdata_d = fb_high_q;
			default:                           rdata_d = pdc_pkg::UNMAPPED_READ;
		endcase
	end

	// a read and a write in one cycle return the old byte
	// read data held until the next read strobe
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= pdc_pkg::UNMAPPED_READ;
		else if (ce_i && reg_rd_i)
			reg_rdata_o <= rdata_d;
	end

	// each byte acts alone: a multi-byte change passes
	// through mixed ratios until the last byte lands
	// field concatenation, upper nibble first
	assign out1_val = {out1_lowspeed_high_i, out1_mid_q, out1_low_q};
	assign out2_val = {out2_high_q[pdc_pkg::NIBBLE_HI:pdc_pkg::NIBBLE_LO], out2_mid_q, out2_low_q};
	assign fb_val   = {fb_high_q[pdc_pkg::NIBBLE_HI:pdc_pkg::NIBBLE_LO], fb_lowspeed_low16_i};

	// hs code plus base gives ratio minus one
	assign out_hs_lim = pdc_pkg::HS_LIMIT_BASE + {1'b0, out_highspeed_code_i};
	assign fb_hs_lim  = pdc_pkg::HS_LIMIT_BASE + {1'b0, fb_high_q[pdc_pkg::HS_CODE_HI:pdc_pkg::HS_CODE_LO]};

	// field values mirrored out from flops for the analog side
	// odd-or-zero is the host's duty, no check here
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			out1_lowspeed_div_o <= '0;
			out2_lowspeed_div_o <= '0;
			fb_lowspeed_div_o   <= '0;
			fb_highspeed_div_o  <= '0;
		end
		else if (ce_i)
		begin
			out1_lowspeed_div_o <= out1_val;
			out2_lowspeed_div_o <= out2_val;
			fb_lowspeed_div_o   <= fb_val;
			fb_highspeed_div_o  <= fb_high_q[pdc_pkg::HS_CODE_HI:pdc_pkg::HS_CODE_LO];
		end
	end

	// both output low-speed stages count the same tick
	// shared output high-speed divider
	pdc_div_cnt #(.W(pdc_pkg::HS_WIDTH)) u_out_hs (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.tick_i  (vco_tick_i),
		.lim_i   (out_hs_lim),
		.pulse_o (out_hs_tick)
	);

	// output one divides by field plus one
	pdc_div_cnt #(.W(LSW)) u_out1_ls (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.tick_i  (out_hs_tick),
		.lim_i   (out1_val),
		.pulse_o (out1_pulse)
	);

	// output two divides by field plus one
	// ratio validity left to the host
	pdc_div_cnt #(.W(LSW)) u_out2_ls (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.tick_i  (out_hs_tick),
		.lim_i   (out2_val),
		.pulse_o (out2_pulse)
	);

	pdc_div_cnt #(.W(pdc_pkg::HS_WIDTH)) u_fb_hs (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.tick_i  (vco_tick_i),
		.lim_i   (fb_hs_lim),
		.pulse_o (fb_hs_tick)
	);

	// odd field expected, giving even ratio
	pdc_div_cnt #(.W(LSW)) u_fb_ls (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.tick_i  (fb_hs_tick),
		.lim_i   (fb_val),
		.pulse_o (fb_pulse)
	);

	// costs one cycle of latency on every pulse
	// retime divider pulses so every output leaves a flop here
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			clock_output_one_o <= 1'b0;
			clock_output_two_o <= 1'b0;
			phase_det_fb_o     <= 1'b0;
		end
		else if (ce_i)
		begin
			clock_output_one_o <= out1_pulse;
			clock_output_two_o <= out2_pulse;
			phase_det_fb_o     <= fb_pulse;
		end
	end
endmodule
`default_nettype wire

//--- verification/pdc_host.sv
// host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module pdc_host (
	input  wire logic		clock_i,	// clock
	output logic [7:0]		addr_o,		// address
	output logic [7:0]		wdata_o,	// data
	output logic			wr_o,		// write
	output logic			rd_o,		// read
	input  wire logic [7:0]	rdata_i		// read data
);
	initial {addr_o, wdata_o, wr_o, rd_o} = 18'h00000;
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clock_i);
		{addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
		@(posedge clock_i);
		// released data flips so no stale byte lingers
		{wdata_o, wr_o, rd_o} <= {~d, 2'b00};
		// read data launched at the taken edge stands at the next one
		@(posedge clock_i);
		q = rdata_i;
	endtask
endmodule
`default_nettype wire

//--- verification/pdc_properties.sv
// assertions on the divider configuration ports
`timescale 1ns/1ps
`default_nettype none
module pdc_props (
	input wire logic		clock_i,		// clock
	input wire logic		rst_i,			// reset
	input wire logic		ce_i,			// enable
	input wire logic [7:0]	reg_addr_i,		// address
	input wire logic [7:0]	reg_wdata_i,		// data
	input wire logic		reg_wr_i,		// write
	input wire logic		reg_rd_i,		// read
	input wire logic [7:0]	reg_rdata_o,		// read data
	input wire logic [19:0]	out2_lowspeed_div_o,	// field two
	input wire logic [19:0]	fb_lowspeed_div_o,	// fb field
	input wire logic [2:0]	fb_highspeed_div_o,	// fb code
	input wire logic		clock_output_one_o,	// pulse one
	input wire logic		clock_output_two_o	// pulse two
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// taken write with its address; fields show it two edges on
	wire [8:0] wa = {ce_i && reg_wr_i, reg_addr_i};
	a_o2_nib: assert property (wa == 9'h122 ##1 ce_i |=> out2_lowspeed_div_o[19:16] == $past(reg_wdata_i[3:0], 2))
		else $error("out2 nibble");
	a_o2_low: assert property (wa == 9'h124 ##1 ce_i |=> out2_lowspeed_div_o[7:0] == $past(reg_wdata_i, 2))
		else $error("out2 low byte");
	a_fb_code: assert property (wa == 9'h128 ##1 ce_i |=> fb_highspeed_div_o == $past(reg_wdata_i[7:5], 2))
		else $error("fb code");
	a_fb_nib: assert property (wa == 9'h128 ##1 ce_i |=> fb_lowspeed_div_o[19:16] == $past(reg_wdata_i[3:0], 2))
		else $error("fb nibble");
	a_rd_hold: assert property (!(ce_i && reg_rd_i) |=> $stable(reg_rdata_o))
		else $error("read data moved");
	a_rd_unmap: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h30 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read");
	// high-speed stage divides by four at least
	a_o1_gap: assert property (ce_i && clock_output_one_o |=> !clock_output_one_o [*3])
		else $error("out1 gap");
	a_o2_gap: assert property (ce_i && clock_output_two_o |=> !clock_output_two_o [*3])
		else $error("out2 gap");
	c_fb_wr: cover property (wa == 9'h128);
	c_o1: cover property (clock_output_one_o);
	c_unmap: cover property (reg_rd_i && reg_addr_i == 8'h30);
endmodule
bind pdc_top pdc_props u_props (.clock_i, .rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .out2_lowspeed_div_o, .fb_lowspeed_div_o, .fb_highspeed_div_o, .clock_output_one_o, .clock_output_two_o);
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the divider configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock_i = 1'b0, rst_i = 1'b1, vco = 1'b0, ce = 1'b1, wr, rd;
	logic [2:0] hs = 3'h0, fhs;
	wire [2:0] p;
	logic [3:0] nib = 4'h0;
	logic [15:0] low16 = 16'h0001;
	logic [7:0] addr, wdata, rdata, rv;
	logic [7:0] ra [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28, 8'h30};
	logic [7:0] rx [7] = '{8'h00, 8'h31, 8'h00, 8'h00, 8'h31, 8'hC0, 8'h00};
	logic [19:0] f1, f2, ff;
	int mismatches = 0, check_count = 0, cyc = 0, cnt [3], per [3];
	always #50 clock_i = ~clock_i;
	pdc_host u_host (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
	pdc_top u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .out1_lowspeed_high_i(nib), .fb_lowspeed_low16_i(low16),
		.out_highspeed_code_i(hs), .vco_tick_i(vco), .out1_lowspeed_div_o(f1), .out2_lowspeed_div_o(f2),
		.fb_lowspeed_div_o(ff), .fb_highspeed_div_o(fhs), .clock_output_one_o(p[0]), .clock_output_two_o(p[1]),
		.phase_det_fb_o(p[2]));
	// cycles between pulses of each output; cyc bounds the run
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		foreach (cnt[i])
			{cnt[i], per[i]} <= p[i] ? {32'h0, cnt[i] + 1} : {cnt[i] + 1, per[i]};
		if (cyc == 20000)
			end_of_test();
	end
	task automatic chk(input logic [19:0] g, input logic [19:0] e);
		check_count++;
		if (g !== e)
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		mismatches += int'(g !== e);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		u_host.access(1'b0, a, 8'h00, rv);
		chk({12'h000, rv}, {12'h000, e});
	endtask
	// a run cut short by the ceiling counts as a mismatch
	task automatic end_of_test();
		if (cyc >= 20000)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t run hit the cycle ceiling", $time);
		end
		$display("mismatches=%0d check_count=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// reset contents and an unmapped read
	task automatic t_reset();
		for (int i = 0; i < 7; i++)
			rdchk(ra[i], rx[i]);
		chk({17'h00000, fhs}, 20'h00006);
		chk(f2, 20'h00031);
	endtask
	// a write with the enable low is not taken; the byte keeps its reset value
	task automatic t_enable();
		ce <= 1'b0;
		u_host.access(1'b1, 8'h21, 8'h55, rv);
		ce <= 1'b1;
		rdchk(8'h21, 8'h31);
	endtask
	// every high-speed code with a tick each cycle; long wait covers two slow periods
	task automatic t_ratio();
		u_host.access(1'b1, 8'h24, 8'h03, rv);
		vco <= 1'b1;
		for (int c = 0; c < 8; c++)
		begin
			hs <= 3'(c);
			u_host.access(1'b1, 8'h28, {3'(c), 5'h00}, rv);
			repeat (1200) @(posedge clock_i);
			chk(20'(per[0]), 20'(50 * c + 200));
			chk(20'(per[1]), 20'(4 * c + 16));
			chk(20'(per[2]), 20'(2 * c + 8));
		end
	endtask
	// write-ignored bits and field assembly
	task automatic t_fields();
		{nib, low16} <= {4'h9, 16'h5A5B};
		u_host.access(1'b1, 8'h22, 8'hFF, rv);
		u_host.access(1'b1, 8'h28, 8'hFF, rv);
		rdchk(8'h22, 8'h0F);
		rdchk(8'h28, 8'hEF);
		chk(f2, 20'hF0003);
		chk(ff, 20'hF5A5B);
		chk(f1, 20'h90031);
	endtask
	initial
	begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset();
		t_enable();
		t_ratio();
		t_fields();
		end_of_test();
	end
endmodule
`default_nettype wire
